// ==== src/srt_translator.sv ====
// module: stepper ring translator top level
`timescale 1ns/100ps
// Overview of operation
// - five-stage johnson ring, strappable shorter
// - eight drops stage 2, six drops 1,2
// - clear puts counter in step one
// - step up or down by stored direction
// - windings A,B,C true; D,E complement
// - falling step edges ORed, strap gated
// - direction latch set by low pulses
// - illegal codes strap-forced back to step one
// - device select high blocks transducer direction
// - enabled feedback rise also steps counter
// - truncate ends feedback; others never masked
// - skip low on query with stages zero
// - unbuffered stage copies provided separately
module srt_translator (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic I_CLEAR,
   input wire logic I_LEN8_STRAP,
   input wire logic I_LEN6_STRAP,
   input wire logic I_STEP_STRAP,
   input wire logic I_ILLEGAL_STRAP,
   input wire logic I_STEP_A_N,
   input wire logic I_STEP_B_N,
   input wire logic I_FWD_N,
   input wire logic I_REV_N,
   input wire logic I_XDCR_DIR,
   input wire logic I_FB_GATE_DIS,
   input wire logic I_FB_STEP,
   input wire logic I_FB_EN,
   input wire logic I_FB_TRUNC_N,
   input wire logic I_SKIP_QUERY_N,
   output logic [4:0] O_WINDING,
   output logic [4:0] O_STAGE_RAW,
   output logic O_DIR_FWD,
   output logic O_SKIP_N
);
   ////////////////////////////////////////////////////////////////////////
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic a_fall, b_fall, fwd_f, rev_f;
   logic fb_rise, xd_rise, xd_f, ft_lvl;
   srt_edge_sync u_sa (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_reg),
      .i_async(I_STEP_A_N),
      .o_level(),
      .o_rise(),
      .o_fall(a_fall)
   );
   srt_edge_sync u_sb (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_reg),
      .i_async(I_STEP_B_N),
      .o_level(),
      .o_rise(),
      .o_fall(b_fall)
   );
   srt_edge_sync u_fw (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_reg),
      .i_async(I_FWD_N),
      .o_level(),
      .o_rise(),
      .o_fall(fwd_f)
   );
   srt_edge_sync u_rv (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_reg),
      .i_async(I_REV_N),
      .o_level(),
      .o_rise(),
      .o_fall(rev_f)
   );
   srt_edge_sync u_fb (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_reg),
      .i_async(I_FB_STEP),
      .o_level(),
      .o_rise(fb_rise),
      .o_fall()
   );
   srt_edge_sync u_xd (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_reg),
      .i_async(I_XDCR_DIR),
      .o_level(),
      .o_rise(xd_rise),
      .o_fall(xd_f)
   );
   srt_edge_sync u_ft (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_reg),
      .i_async(I_FB_TRUNC_N),
      .o_level(ft_lvl),
      .o_rise(),
      .o_fall()
   );

   ////////////////////////////////////////////////////////////////////////
   // next johnson code with stage skipping for shortened rings
   function automatic logic [4:0] ring_step(input logic [4:0] q, input logic up,
                                            input srt_pkg::srt_len_t len);
      logic [4:0] n;
      n = q;
      if (up) begin
         n = {q[3:0], ~q[4]};
         if (len == srt_pkg::SRT_LEN8) begin
            n[2] = q[1];
            n[3] = q[1];
         end else if (len == srt_pkg::SRT_LEN6) begin
            n[1] = q[0];
            n[2] = q[0];
            n[3] = q[0];
         end
      end else begin
         n = {q[0], q[4:1]};
         n[4] = ~q[0];
         if (len == srt_pkg::SRT_LEN8) begin
            n[1] = q[3];
            n[2] = q[3];
         end else if (len == srt_pkg::SRT_LEN6) begin
            n[0] = q[3];
            n[1] = q[3];
            n[2] = q[3];
         end
      end
      return n;
   endfunction

   // a johnson code has at most one boundary between runs
   function automatic logic ring_legal(input logic [4:0] q);
      logic [4:0] d;
      d = q ^ {q[3:0], ~q[4]};
      return (d[0] + d[1] + d[2] + d[3] + d[4]) == 3'd1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   srt_pkg::srt_len_t len;
   always_comb begin
      if (I_LEN6_STRAP) begin
         len = srt_pkg::SRT_LEN6;
      end else if (I_LEN8_STRAP) begin
         len = srt_pkg::SRT_LEN8;
      end else begin
         len = srt_pkg::SRT_LEN10;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic dir_reg, dir_next;
   always_comb begin
      dir_next = dir_reg;
      if (xd_rise && !I_FB_GATE_DIS) begin
         dir_next = 1'b1;
      end
      if (xd_f && !I_FB_GATE_DIS) begin
         dir_next = 1'b0;
      end
      if (fwd_f) begin
         dir_next = 1'b1;
      end
      if (rev_f) begin
         dir_next = 1'b0;
      end
   end
   always_ff @(posedge I_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dir_reg <= 1'b1;
      end else begin
         dir_reg <= dir_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // feedback gate: armed on rise, closed by truncate; it is edge based,
   // so a long high feedback phase never hides the other step inputs
   logic fb_step;
   logic step;
   assign fb_step = fb_rise & I_FB_EN & ft_lvl;
   assign step = I_STEP_STRAP & (a_fall | b_fall) | fb_step;

   logic [4:0] ring_reg, ring_next;
   always_comb begin
      ring_next = ring_reg;
      if (I_CLEAR) begin
         ring_next = srt_pkg::RING_RESET;
      end else if (I_ILLEGAL_STRAP && !ring_legal(ring_reg) && ring_reg != 5'h00 &&
                   ring_reg != 5'h1f) begin
         ring_next = srt_pkg::RING_RESET;
      end else if (step) begin
         ring_next = ring_step(ring_reg, dir_reg, len);
      end
   end
   always_ff @(posedge I_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ring_reg <= srt_pkg::RING_RESET;
      end else begin
         ring_reg <= ring_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [4:0] wind_reg, wind_next;
   logic skip_n_reg, skip_n_next;
   always_comb begin
      wind_next[0] = ring_reg[srt_pkg::STAGE_A];
      wind_next[1] = ring_reg[srt_pkg::STAGE_B];
      wind_next[2] = ring_reg[srt_pkg::STAGE_C];
      wind_next[3] = ~ring_reg[srt_pkg::STAGE_D];
      wind_next[4] = ~ring_reg[srt_pkg::STAGE_E];
      skip_n_next = ~(~I_SKIP_QUERY_N & ~ring_reg[srt_pkg::SKIP_STAGE_LO] &
                      ~ring_reg[srt_pkg::SKIP_STAGE_HI]);
   end
   always_ff @(posedge I_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wind_reg <= 5'h18;
         skip_n_reg <= 1'b1;
      end else begin
         wind_reg <= wind_next;
         skip_n_reg <= skip_n_next;
      end
   end

   assign O_WINDING = wind_reg;
   assign O_STAGE_RAW = ring_reg;
   assign O_DIR_FWD = dir_reg;
   assign O_SKIP_N = skip_n_reg;

   ////////////////////////////////////////////////////////////////////////
   clear_state_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      I_CLEAR |=> ring_reg == 5'h00) else $error("clear missed step one");
   fwd_dir_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      fwd_f && !rev_f |=> dir_reg) else $error("forward not latched");
   rev_dir_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      rev_f |=> !dir_reg) else $error("reverse not latched");
   winding_map_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      ##1 O_WINDING == {~$past(ring_reg[3]), ~$past(ring_reg[1]), $past(ring_reg[4]),
      $past(ring_reg[2]), $past(ring_reg[0])}) else $error("winding map wrong");
   hold_nostep_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      !step && !I_CLEAR && ring_legal(ring_reg) |=> $stable(ring_reg))
      else $error("ring moved without step");
   skip_resp_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      I_SKIP_QUERY_N |=> O_SKIP_N) else $error("skip without query");
   gate_dis_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      I_FB_GATE_DIS && !fwd_f && !rev_f |=> $stable(dir_reg))
      else $error("transducer moved direction");
   len8_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      len == srt_pkg::SRT_LEN8 && step && !I_CLEAR && ring_legal(ring_reg) |=>
      ring_reg[2] == ring_reg[1] || ring_reg[2] == ring_reg[3])
      else $error("stage 2 not bypassed");
   trunc_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      !ft_lvl && !(I_STEP_STRAP && (a_fall || b_fall)) && !I_CLEAR &&
      ring_legal(ring_reg) |=> $stable(ring_reg)) else $error("truncate ignored");
   // a step edge on strapped input A moves the ring whatever feedback does
   step_moves_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      I_STEP_STRAP && a_fall && !I_CLEAR && ring_legal(ring_reg) |=> !$stable(ring_reg))
      else $error("step edge masked");
   fb_step_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      fb_rise && I_FB_EN && ft_lvl && !I_CLEAR && ring_legal(ring_reg) |=>
      !$stable(ring_reg)) else $error("feedback step lost");
   fb_block_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      fb_rise && !I_FB_EN && !(I_STEP_STRAP && (a_fall || b_fall)) && !I_CLEAR &&
      ring_legal(ring_reg) |=> $stable(ring_reg)) else $error("disabled feedback stepped");
   illegal_fix_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      I_ILLEGAL_STRAP && !I_CLEAR && !ring_legal(ring_reg) |=> ring_reg == 5'h00)
      else $error("illegal code kept");
   ring_legal_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      ring_legal(ring_reg) |=> ring_legal(ring_reg)) else $error("ring left johnson codes");
   len6_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      len == srt_pkg::SRT_LEN6 && step && !I_CLEAR && ring_legal(ring_reg) |=>
      ring_reg[1] == ring_reg[2]) else $error("stages 1 2 not bypassed");
   up_first_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      step && dir_reg && len == srt_pkg::SRT_LEN10 && !I_CLEAR && ring_reg == 5'h00 |=>
      ring_reg == 5'h01) else $error("ascending order wrong");
   down_wrap_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      step && !dir_reg && len == srt_pkg::SRT_LEN10 && !I_CLEAR && ring_reg == 5'h00 |=>
      ring_reg == 5'h10) else $error("descending wrap wrong");
   skip_on_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      !I_SKIP_QUERY_N && !ring_reg[srt_pkg::SKIP_STAGE_LO] &&
      !ring_reg[srt_pkg::SKIP_STAGE_HI] |=> !O_SKIP_N) else $error("skip not given");
   xdcr_dir_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      xd_rise && !I_FB_GATE_DIS && !fwd_f && !rev_f |=> dir_reg)
      else $error("transducer direction lost");
   // one synchronised edge gives a single step pulse
   one_pulse_a: assert property (@(posedge I_CLK) disable iff (!rst_n_reg)
      a_fall |=> !a_fall) else $error("double step pulse");
endmodule // srt_translator

// ==== src/srt_pkg.sv ====
// package: constants and types for the stepper ring translator
package srt_pkg;
   localparam int STAGES = 5;
   localparam logic [4:0] RING_RESET = 5'h00;
   localparam int CLK_PERIOD_NS = 50;
   localparam int FB_HIGH_MIN_US = 20;
   localparam int FB_HIGH_MAX_US = 100;
   localparam int FB_HIGH_MAX_CYC = (FB_HIGH_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int STAGE_A = 0;
   localparam int STAGE_B = 2;
   localparam int STAGE_C = 4;
   localparam int STAGE_D = 1;
   localparam int STAGE_E = 3;
   localparam int SKIP_STAGE_LO = 0;
   localparam int SKIP_STAGE_HI = 1;
   typedef enum logic [2:0] {
      SRT_LEN10 = 3'h1,
      SRT_LEN8 = 3'h2,
      SRT_LEN6 = 3'h4
   } srt_len_t;
endpackage

// ==== src/srt_edge_sync.sv ====
// module: two-flop synchroniser with rise and fall detection
`timescale 1ns/100ps
module srt_edge_sync (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_async,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   logic meta_next;
   logic sync_next;
   logic last_next;

   always_comb begin
      meta_next = i_async;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign o_level = sync_reg;
   assign o_rise = sync_reg & ~last_reg;
   assign o_fall = ~sync_reg & last_reg;
endmodule // srt_edge_sync

// ==== testbench/srt_motor_model.sv ====
// winding driver and motor model: turns the energised pattern into a step position
`timescale 1ns/100ps
module srt_motor_model (
   input wire logic [4:0] i_winding,
   output logic [3:0] o_state
);
   // 0 means the pattern is not one the ten-step ring can make
   always_comb begin
      case (i_winding)
         5'h18: o_state = 4'h1;
         5'h19: o_state = 4'h2;
         5'h11: o_state = 4'h3;
         5'h13: o_state = 4'h4;
         5'h03: o_state = 4'h5;
         5'h07: o_state = 4'h6;
         5'h06: o_state = 4'h7;
         5'h0e: o_state = 4'h8;
         5'h0c: o_state = 4'h9;
         5'h1c: o_state = 4'ha;
         default: o_state = 4'h0;
      endcase
   end
endmodule // srt_motor_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the stepper ring translator
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'b0, arst_n = 1'b0, clr = 1'b0, l8 = 1'b0, l6 = 1'b0, strap = 1'b1;
   logic sa = 1'b1, sb = 1'b1, fw = 1'b1, rv = 1'b1, xd = 1'b0, gd = 1'b0;
   logic fb = 1'b0, fen = 1'b1, tr = 1'b1, sq = 1'b1, dir = 1'b1, mon = 1'b0, ill = 1'b1;
   logic [4:0] win, raw, e, ex, last;
   logic dfwd, skn;
   logic [3:0] mst;
   logic [4:0] eq[$];
   int pq[$];
   int ln = 0, pos = 1, p, seed = 94875, n_mismatch = 0, checked = 0;
   srt_translator dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .I_CLEAR(clr), .I_LEN8_STRAP(l8),
      .I_LEN6_STRAP(l6), .I_STEP_STRAP(strap), .I_ILLEGAL_STRAP(ill), .I_STEP_A_N(sa),
      .I_STEP_B_N(sb), .I_FWD_N(fw), .I_REV_N(rv), .I_XDCR_DIR(xd), .I_FB_GATE_DIS(gd),
      .I_FB_STEP(fb), .I_FB_EN(fen), .I_FB_TRUNC_N(tr), .I_SKIP_QUERY_N(sq),
      .O_WINDING(win), .O_STAGE_RAW(raw), .O_DIR_FWD(dfwd), .O_SKIP_N(skn));
   srt_motor_model mot_u (.i_winding(win), .o_state(mst));
   initial begin
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] nxt(input logic [4:0] c, input logic f);
      int ix[5];
      int n;
      logic [4:0] r;
      ix = '{0, 1, 2, 3, 4};
      n = 5 - ln;
      if (ln == 1) ix = '{0, 1, 3, 4, 4};
      if (ln == 2) ix = '{0, 3, 4, 4, 4};
      r = c;
      r[f ? ix[0] : ix[n-1]] = ~c[f ? ix[n-1] : ix[0]];
      for (int k = 1; k < n; k++) begin
         if (f) r[ix[k]] = c[ix[k-1]];
         else r[ix[k-1]] = c[ix[k]];
      end
      return r;
   endfunction
   task automatic cmp(input logic [4:0] g, input logic [4:0] x, input logic [4:0] m,
                      input string w);
      checked++;
      if ((g & m) !== (x & m)) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, w, g, x);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic push;
      ex = nxt(ex, dir);
      pos = dir ? pos % 10 + 1 : (pos + 8) % 10 + 1;
      eq.push_back(ex);
      pq.push_back(pos);
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // results appear as ring changes; the oldest note is taken off and compared
   always @(negedge clk) begin
      if (mon && raw !== last) begin
         last = raw;
         if (eq.size() == 0) begin
            n_mismatch++;
            $display("MISMATCH at %0t: step without cause", $time);
         end else begin
            e = eq.pop_front();
            p = pq.pop_front();
            cmp(raw, e, ln == 0 ? 5'h1f : ln == 1 ? 5'h1b : 5'h19, "stage");
            @(negedge clk);
            cmp(win, {~e[3], ~e[1], e[4], e[2], e[0]}, ln == 0 ? 5'h1f : ln == 1 ? 5'h1d : 5'h15,
                "winding");
            if (ln == 0) cmp({1'b0, mst}, p[4:0], 5'h1f, "position");
         end
      end
   end
   initial begin
      #(50 * 20000);
      n_mismatch++;
      give_verdict;
   end
   initial begin
      int k;
      cyc(10);
      arst_n <= 1'b1;
      cyc(8);
      for (ln = 0; ln < 3; ln++) begin
         mon = 1'b0;
         l8 <= ln == 1;
         l6 <= ln == 2;
         clr <= 1'b1;
         cyc(3);
         clr <= 1'b0;
         cyc(4);
         #1;
         cmp(raw, 5'h00, 5'h1f, "clear");
         last = raw;
         ex = 5'h00;
         pos = 1;
         mon = 1'b1;
         for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            k = $unsigned($random(seed)) % 7;
            strap <= $random(seed) % 4 != 0;
            fen <= $random(seed) % 3 != 0;
            tr <= $random(seed) % 4 != 0;
            gd <= $random(seed) % 2 != 0;
            cyc(3);
            case (k)
               0, 1: begin
                  if (k == 0) sa <= 1'b0;
                  else sb <= 1'b0;
                  if (strap) push;
                  cyc(4);
                  sa <= 1'b1;
                  sb <= 1'b1;
               end
               2: begin
                  fb <= 1'b1;
                  if (fen && tr) push;
                  cyc(6);
                  sa <= 1'b0;
                  if (strap) push;
                  cyc(4);
                  sa <= 1'b1;
                  fb <= 1'b0;
               end
               3, 4: begin
                  if (k == 3) fw <= 1'b0;
                  else rv <= 1'b0;
                  dir = k == 3;
                  cyc(4);
                  fw <= 1'b1;
                  rv <= 1'b1;
               end
               5: begin
                  xd <= ~xd;
                  if (!gd) dir = ~xd;
               end
               default: begin
                  sq <= 1'b0;
                  cyc(6);
                  #1;
                  if (ln == 0) cmp({4'h0, skn}, {4'h0, ex[1:0] != 2'h0}, 5'h01, "skip");
                  @(posedge clk);
                  sq <= 1'b1;
                  cyc(6);
                  #1;
                  cmp({4'h0, skn}, 5'h01, 5'h01, "skip idle");
               end
            endcase
            cyc(8);
            #1;
            cmp({4'h0, dfwd}, {4'h0, dir}, 5'h01, "direction");
         end
         cyc(6);
         if (eq.size() != 0) cmp(5'h00, 5'h01, 5'h01, "missed step");
         eq.delete();
         pq.delete();
      end
      give_verdict;
   end
endmodule // tb_top
